// file: design/dscp_pkg.sv
package dscp_pkg;

	localparam int WORD_W = 18;

	// Control word field positions
	localparam int FORCE_KIND_POS = 17;
	localparam int GAIN_POL_POS = 16;
	localparam int GAIN_HIGH_POS = 15;
	localparam int GAIN_LOW_POS = 14;
	localparam int RANGE_EXT_POS = 13;
	localparam int RANGE_MID_POS = 12;
	localparam int RANGE_LOW_POS = 11;
	localparam int CLAMP_POS = 10;
	localparam int RESERVED_POS = 9;
	localparam int FORCE_OE_POS = 8;
	localparam int MEAS_HIZ_POS = 7;
	localparam int CMP_HIZ_POS = 6;
	localparam int LEAD_HIGH_POS = 5;
	localparam int LEAD_LOW_POS = 4;
	localparam int BYPASS_HIGH_POS = 3;
	localparam int BYPASS_LOW_POS = 2;
	localparam int STAGE_LOAD_POS = 1;
	localparam int ACTIVE_LOAD_POS = 0;

	// Power-up word decodes to hi-Z force mode and disabled measure outputs, with comparator hi-Z off
	localparam logic [17:0] WORD_RESET = 18'h00000;

	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int CS_MIN_LOW_NS = 40;
	localparam int CS_MIN_LOW_CYC = (CS_MIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CS_CNT_W = 4;
	localparam logic [3:0] CS_CNT_MAX = 4'hF;
	localparam logic [3:0] CS_MIN_LOW_CNT = 4'(CS_MIN_LOW_CYC);

	// Pin synchroniser: {sclk, din, cs_n, load_n, measure_hiz_pin_n}
	localparam int SYNC_W = 5;
	localparam logic [4:0] SYNC_RESET = 5'h06;

	typedef enum logic [1:0] {
		mode_hiz,
		mode_slave_current,
		mode_voltage_forcing,
		mode_current_forcing
	} dscp_mode_t;

	typedef enum logic [2:0] {
		range_d,
		range_c,
		range_b,
		range_a,
		range_external
	} dscp_range_t;

	typedef enum logic [1:0] {
		gain_x1,
		gain_x2,
		gain_x6,
		gain_unused
	} dscp_gain_t;

	function automatic dscp_range_t decode_range(input logic [2:0] code);
		if (code[2]) begin
			return range_external;
		end
		case (code[1:0])
			2'h0: return range_d;
			2'h1: return range_c;
			2'h2: return range_b;
			default: return range_a;
		endcase
	endfunction : decode_range

	function automatic dscp_mode_t decode_mode(input logic force_oe, input logic force_kind);
		case ({force_oe, force_kind})
			2'h0: return mode_hiz;
			2'h1: return mode_slave_current;
			2'h2: return mode_voltage_forcing;
			default: return mode_current_forcing;
		endcase
	endfunction : decode_mode

	function automatic dscp_gain_t decode_gain(input logic [1:0] code);
		case (code)
			2'h0: return gain_x1;
			2'h1: return gain_x2;
			2'h2: return gain_x6;
			default: return gain_unused;
		endcase
	endfunction : decode_gain

endpackage : dscp_pkg

// file: design/dscp_sync.sv
`timescale 1ns/1ps
module dscp_sync (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [4:0] async_in,
	output logic [4:0] sync_out
);
	logic [4:0] meta;
	logic [4:0] next_meta;
	logic [4:0] next_sync;

	// First stage feeds only the second stage
	always_comb begin
		next_meta = async_in;
		next_sync = meta;
		if (rst_in) begin
			next_meta = dscp_pkg::SYNC_RESET;
			next_sync = dscp_pkg::SYNC_RESET;
		end
	end

	always_ff @(posedge clk_in) begin
		meta <= next_meta;
		sync_out <= next_sync;
	end
endmodule : dscp_sync

// file: design/dscp_shift.sv
`timescale 1ns/1ps
module dscp_shift (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic shift_en_in,
	input wire logic fall_en_in,
	input wire logic bit_in,
	output logic [17:0] word_out,
	output logic dout_out
);
	logic [17:0] next_word;
	logic next_dout;

	always_comb begin
		next_word = word_out;
		next_dout = dout_out;
		if (shift_en_in) begin
			next_word = {word_out[16:0], bit_in};
		end
		// Oldest bit leaves on the falling edge so a chained part samples it on the next rise
		if (fall_en_in) begin
			next_dout = word_out[17];
		end
		if (rst_in) begin
			next_word = dscp_pkg::WORD_RESET;
			next_dout = 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		word_out <= next_word;
		dout_out <= next_dout;
	end
endmodule : dscp_shift

// file: design/dscp_serial_control_port.sv
// Summary of operation
// - The 18-bit word holds mode, gain, range, clamp, hi-Z, compensation and transfer fields.
// - Bits 1 and 0 choose the register transfer, done when chip select rises.
// - Both transfer bits zero: staging and active registers stay unchanged.
// - Bits 01: staging register is copied into the active register.
// - Bits 10: shift word goes into staging only.
// - Bits 11: shift word goes into staging and active.
// - Load strobe low at chip select rise passes staged word into active too.
// - A clockless chip select pulse of minimum width copies staging into active.
// - Range field decodes to D, C, B, A, or external when bit 13 set.
// - Gain field sets gain 1, 2 or 6; bit 16 negates force gain.
// - Bits 8 and 17 pick hi-Z, slave current, voltage or current forcing.
// - Measure hi-Z depends jointly on bit 7 and the measure hi-Z pin.
// - Serial output replays shifted bits in order, 18 clocks behind the input.
// - Serial output changes on the falling serial clock edge.
// - Only the active register drives the decoded controls.
// - A low load strobe copies staging into active without the serial clock.
// - Measure outputs are enabled only when bit 7 and the pin are both one.
`timescale 1ns/1ps
module dscp_serial_control_port (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic sclk_in,
	input wire logic din_in,
	input wire logic cs_n_in,
	input wire logic load_n_in,
	input wire logic measure_hiz_pin_n_in,
	output logic dout_out,
	output logic [17:0] staging_word_out,
	output logic [17:0] active_word_out,
	output dscp_pkg::dscp_mode_t mode_out,
	output dscp_pkg::dscp_range_t range_out,
	output dscp_pkg::dscp_gain_t gain_out,
	output logic force_gain_negative_out,
	output logic clamp_enable_out,
	output logic measure_enable_out,
	output logic comparator_hiz_out,
	output logic [1:0] lead_comp_out,
	output logic [1:0] bypass_comp_out
);
	logic sclk_s;
	logic din_s;
	logic cs_n_s;
	logic load_n_s;
	logic measure_hiz_pin_n_s;

	dscp_sync u_sync (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.async_in({sclk_in, din_in, cs_n_in, load_n_in, measure_hiz_pin_n_in}),
		.sync_out({sclk_s, din_s, cs_n_s, load_n_s, measure_hiz_pin_n_s})
	);

	// Frame tracking
	logic sclk_q;
	logic cs_n_q;
	logic saw_clk;
	logic [3:0] low_cnt;
	logic next_sclk_q;
	logic next_cs_n_q;
	logic next_saw_clk;
	logic [3:0] next_low_cnt;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_fall;
	logic cs_rise;
	logic shift_en;
	logic fall_en;
	logic frame_done;
	logic quick_load;

	always_comb begin
		sclk_rise = sclk_s & ~sclk_q;
		sclk_fall = ~sclk_s & sclk_q;
		cs_fall = ~cs_n_s & cs_n_q;
		cs_rise = cs_n_s & ~cs_n_q;
		shift_en = sclk_rise & ~cs_n_s;
		fall_en = sclk_fall & ~cs_n_s;
		frame_done = cs_rise & saw_clk;
		quick_load = cs_rise & ~saw_clk & (low_cnt >= dscp_pkg::CS_MIN_LOW_CNT);
	end

	always_comb begin
		next_sclk_q = sclk_s;
		next_cs_n_q = cs_n_s;
		next_saw_clk = saw_clk;
		next_low_cnt = low_cnt;
		if (cs_fall) begin
			next_saw_clk = shift_en;
			next_low_cnt = 4'h1;
		end else if (!cs_n_s) begin
			// Any edge count marks a data frame, not only a full word
			if (shift_en) begin
				next_saw_clk = 1'b1;
			end
			if (low_cnt != dscp_pkg::CS_CNT_MAX) begin
				next_low_cnt = low_cnt + 4'h1;
			end
		end
		if (rst_in) begin
			next_sclk_q = 1'b0;
			next_cs_n_q = 1'b1;
			next_saw_clk = 1'b0;
			next_low_cnt = 4'h0;
		end
	end

	always_ff @(posedge clk_in) begin
		sclk_q <= next_sclk_q;
		cs_n_q <= next_cs_n_q;
		saw_clk <= next_saw_clk;
		low_cnt <= next_low_cnt;
	end

	logic [17:0] shift_word;

	dscp_shift u_shift (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.shift_en_in(shift_en),
		.fall_en_in(fall_en),
		.bit_in(din_s),
		.word_out(shift_word),
		.dout_out(dout_out)
	);

	// Staging, active and decoded controls
	logic [17:0] next_staging;
	logic [17:0] next_active;
	dscp_pkg::dscp_mode_t next_mode;
	dscp_pkg::dscp_range_t next_range;
	dscp_pkg::dscp_gain_t next_gain;
	logic next_negative;
	logic next_clamp;
	logic next_meas_en;
	logic next_cmp_hiz;
	logic [1:0] next_lead;
	logic [1:0] next_bypass;

	always_comb begin
		next_staging = staging_word_out;
		next_active = active_word_out;
		if (frame_done) begin
			if (shift_word[dscp_pkg::STAGE_LOAD_POS]) begin
				next_staging = shift_word;
			end
			if (shift_word[dscp_pkg::ACTIVE_LOAD_POS]) begin
				if (shift_word[dscp_pkg::STAGE_LOAD_POS]) begin
					next_active = shift_word;
				end else begin
					next_active = staging_word_out;
				end
			end
			// Code 00 falls through with both registers held
		end
		if (quick_load) begin
			next_active = staging_word_out;
		end
		// Transparent while low, so a word staged in this cycle passes straight on
		if (!load_n_s) begin
			next_active = next_staging;
		end
		// Decodes are taken from the active word, with the measure hi-Z pin also gating measure enable
		next_mode = dscp_pkg::decode_mode(next_active[dscp_pkg::FORCE_OE_POS],
			next_active[dscp_pkg::FORCE_KIND_POS]);
		next_range = dscp_pkg::decode_range(next_active[dscp_pkg::RANGE_EXT_POS:dscp_pkg::RANGE_LOW_POS]);
		next_gain = dscp_pkg::decode_gain(next_active[dscp_pkg::GAIN_HIGH_POS:dscp_pkg::GAIN_LOW_POS]);
		next_negative = next_active[dscp_pkg::GAIN_POL_POS];
		next_clamp = next_active[dscp_pkg::CLAMP_POS];
		next_meas_en = next_active[dscp_pkg::MEAS_HIZ_POS] & measure_hiz_pin_n_s;
		next_cmp_hiz = next_active[dscp_pkg::CMP_HIZ_POS];
		next_lead = next_active[dscp_pkg::LEAD_HIGH_POS:dscp_pkg::LEAD_LOW_POS];
		next_bypass = next_active[dscp_pkg::BYPASS_HIGH_POS:dscp_pkg::BYPASS_LOW_POS];
		if (rst_in) begin
			next_staging = dscp_pkg::WORD_RESET;
			next_active = dscp_pkg::WORD_RESET;
			next_mode = dscp_pkg::mode_hiz;
			next_range = dscp_pkg::range_d;
			next_gain = dscp_pkg::gain_x1;
			next_negative = 1'b0;
			next_clamp = 1'b0;
			next_meas_en = 1'b0;
			next_cmp_hiz = 1'b0;
			next_lead = 2'h0;
			next_bypass = 2'h0;
		end
	end

	always_ff @(posedge clk_in) begin
		staging_word_out <= next_staging;
		active_word_out <= next_active;
		mode_out <= next_mode;
		range_out <= next_range;
		gain_out <= next_gain;
		force_gain_negative_out <= next_negative;
		clamp_enable_out <= next_clamp;
		measure_enable_out <= next_meas_en;
		comparator_hiz_out <= next_cmp_hiz;
		lead_comp_out <= next_lead;
		bypass_comp_out <= next_bypass;
	end

	// Checks
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);

	shift_order_a: assert property (shift_en |=> shift_word == {$past(shift_word[16:0]), $past(din_s)})
		else $error("shift register did not take serial input MSB first");

	dout_fall_a: assert property (fall_en |=> dout_out == $past(shift_word[17]))
		else $error("serial output did not follow oldest bit on falling edge");

	dout_hold_a: assert property (!fall_en |=> $stable(dout_out))
		else $error("serial output changed away from a falling edge");

	nop_hold_a: assert property (frame_done && shift_word[1:0] == 2'h0 && load_n_s
		|=> $stable(staging_word_out) && $stable(active_word_out))
		else $error("no-op frame changed a register");

	active_from_stage_a: assert property (frame_done && shift_word[1:0] == 2'h1
		|=> active_word_out == $past(staging_word_out) && $stable(staging_word_out))
		else $error("active register not loaded from staging");

	stage_only_a: assert property (frame_done && shift_word[1:0] == 2'h2 && load_n_s
		|=> staging_word_out == $past(shift_word) && $stable(active_word_out))
		else $error("staging-only frame handled wrongly");

	both_load_a: assert property (frame_done && shift_word[1:0] == 2'h3
		|=> staging_word_out == $past(shift_word) && active_word_out == $past(shift_word))
		else $error("both registers not loaded from shift word");

	load_override_a: assert property (frame_done && shift_word[1] && !load_n_s
		|=> active_word_out == $past(shift_word))
		else $error("load strobe did not pass staged word to active");

	quick_load_a: assert property (cs_rise && !saw_clk && low_cnt >= dscp_pkg::CS_MIN_LOW_CNT
		|=> active_word_out == $past(staging_word_out))
		else $error("quick load did not copy staging to active");

	short_pulse_a: assert property (cs_rise && !saw_clk && low_cnt < dscp_pkg::CS_MIN_LOW_CNT && load_n_s
		|=> $stable(active_word_out))
		else $error("short chip select pulse changed active register");

	load_level_a: assert property (!load_n_s && !frame_done |=> active_word_out == $past(staging_word_out))
		else $error("low load strobe did not copy staging");

	range_decode_a: assert property (active_word_out[13] |-> range_out == dscp_pkg::range_external)
		else $error("range external not decoded");

	mode_decode_a: assert property (mode_out == dscp_pkg::decode_mode(active_word_out[8], active_word_out[17]))
		else $error("mode does not follow active register");

	meas_enable_a: assert property (##1 measure_enable_out == (active_word_out[7] && $past(measure_hiz_pin_n_s)))
		else $error("measure enable not the AND of bit and pin");

	// Registers move only on their own triggers; shifted data alone never reaches the controls
	stage_hold_a: assert property (!frame_done |=> $stable(staging_word_out))
		else $error("staging register changed outside a frame end");

	active_hold_a: assert property (!frame_done && !quick_load && load_n_s |=> $stable(active_word_out))
		else $error("active register changed with no transfer");

	idle_shift_a: assert property (cs_n_s |=> $stable(shift_word))
		else $error("shift register moved while deselected");

	idle_dout_a: assert property (cs_n_s |=> $stable(dout_out))
		else $error("serial output moved while deselected");

	count_sat_a: assert property (!cs_n_s && !cs_fall && low_cnt == dscp_pkg::CS_CNT_MAX
		|=> low_cnt == dscp_pkg::CS_CNT_MAX)
		else $error("low pulse counter wrapped");

	pin_off_a: assert property (!measure_hiz_pin_n_s |=> !measure_enable_out)
		else $error("measure output enabled with the pin low");

	range_top_a: assert property (active_word_out[dscp_pkg::RANGE_EXT_POS:dscp_pkg::RANGE_LOW_POS] == 3'h3
		|-> range_out == dscp_pkg::range_a)
		else $error("highest range not decoded");

	gain_six_a: assert property (active_word_out[dscp_pkg::GAIN_HIGH_POS:dscp_pkg::GAIN_LOW_POS] == 2'h2
		|-> gain_out == dscp_pkg::gain_x6)
		else $error("gain six not decoded");

	gain_sign_a: assert property (force_gain_negative_out == active_word_out[dscp_pkg::GAIN_POL_POS])
		else $error("force gain sign does not follow active word");

	slave_mode_a: assert property (!active_word_out[dscp_pkg::FORCE_OE_POS]
		&& active_word_out[dscp_pkg::FORCE_KIND_POS] |-> mode_out == dscp_pkg::mode_slave_current)
		else $error("slave current mode not decoded");

	hiz_mode_a: assert property (!active_word_out[dscp_pkg::FORCE_OE_POS]
		&& !active_word_out[dscp_pkg::FORCE_KIND_POS] |-> mode_out == dscp_pkg::mode_hiz)
		else $error("high impedance mode not decoded");

	fields_follow_a: assert property (clamp_enable_out == active_word_out[dscp_pkg::CLAMP_POS]
		&& comparator_hiz_out == active_word_out[dscp_pkg::CMP_HIZ_POS]
		&& lead_comp_out == active_word_out[dscp_pkg::LEAD_HIGH_POS:dscp_pkg::LEAD_LOW_POS]
		&& bypass_comp_out == active_word_out[dscp_pkg::BYPASS_HIGH_POS:dscp_pkg::BYPASS_LOW_POS])
		else $error("plain control fields do not follow active word");

	cover property (frame_done && shift_word[1:0] == 2'h3);
	cover property (frame_done && shift_word[1:0] == 2'h2 ##[1:400] !load_n_s);
	cover property (quick_load);
	cover property (frame_done && shift_word[1:0] == 2'h0);
	cover property (frame_done && !load_n_s && shift_word[dscp_pkg::STAGE_LOAD_POS]);

endmodule : dscp_serial_control_port

// file: verif/dscp_host_model.sv
`timescale 1ns/1ps
module dscp_host_model (
	input wire logic clk_in,
	input wire logic dout_in,
	output logic sclk_out,
	output logic din_out,
	output logic cs_n_out
);
	logic in_frame;

	initial begin
		sclk_out = 1'b0;
		din_out = 1'b0;
		cs_n_out = 1'b1;
		in_frame = 1'b0;
	end

	// Released data line toggles so the port cannot lean on a stale level
	always @(posedge clk_in) begin
		if (!in_frame) begin
			din_out <= ~din_out;
		end
	end

	// Low phase alternates 6 and 7 cycles, high 6: mean period 125 ns
	task automatic frame(input logic [17:0] w, input int n, input int hold, output logic [31:0] got);
		int i;
		got = '0;
		@(posedge clk_in);
		in_frame <= 1'b1;
		cs_n_out <= 1'b0;
		for (i = 0; i < n; i++) begin
			@(posedge clk_in);
			sclk_out <= 1'b0;
			din_out <= w[17 - (i % 18)];
			repeat (5 + (i % 2)) @(posedge clk_in);
			@(negedge clk_in);
			got = {got[30:0], dout_in};
			@(posedge clk_in);
			sclk_out <= 1'b1;
			repeat (5) @(posedge clk_in);
		end
		sclk_out <= 1'b0;
		repeat (hold) @(posedge clk_in);
		cs_n_out <= 1'b1;
		in_frame <= 1'b0;
	endtask : frame
endmodule : dscp_host_model

// file: verif/test_dscp_serial_control_port.sv
`timescale 1ns/1ps
module test_dscp_serial_control_port;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic load_n_in = 1'b1;
	logic pin_n = 1'b1;
	logic sclk, din, cs_n, dout;
	logic [17:0] stg_w, act_w;
	dscp_pkg::dscp_mode_t mode;
	dscp_pkg::dscp_range_t range;
	dscp_pkg::dscp_gain_t gain;
	logic neg, clamp, meas_en, cmp_hiz;
	logic [1:0] lead, bypass;
	int failures = 0;
	int n_compared = 0;
	integer seed = 75;
	logic [17:0] sh, stg, act, w;
	logic [31:0] got, exp_d;
	logic [14:0] dec;

	always #5 clk_in = ~clk_in;

	dscp_serial_control_port i_dscp_serial_control_port (.clk_in(clk_in), .rst_in(rst_in), .sclk_in(sclk),
		.din_in(din), .cs_n_in(cs_n), .load_n_in(load_n_in), .measure_hiz_pin_n_in(pin_n), .dout_out(dout),
		.staging_word_out(stg_w), .active_word_out(act_w), .mode_out(mode), .range_out(range),
		.gain_out(gain), .force_gain_negative_out(neg), .clamp_enable_out(clamp),
		.measure_enable_out(meas_en), .comparator_hiz_out(cmp_hiz), .lead_comp_out(lead),
		.bypass_comp_out(bypass));

	dscp_host_model i_dscp_host_model (.clk_in(clk_in), .dout_in(dout), .sclk_out(sclk), .din_out(din),
		.cs_n_out(cs_n));

	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : final_report

	task automatic chk_word(input logic [17:0] g, input logic [17:0] e, input string what);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("BAD t=%0t %s got %h exp %h", $time, what, g, e);
		end
	endtask : chk_word

	task automatic chk_dec(input logic [14:0] g, input logic [14:0] e);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("BAD t=%0t decode got %h exp %h", $time, g, e);
		end
	endtask : chk_dec

	task automatic chk_dout(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("BAD t=%0t dout got %h exp %h", $time, g, e);
		end
	endtask : chk_dout

	// Field order follows the output enums: mode, range, gain, sign, clamp, meas, cmp, lead, bypass
	function automatic logic [14:0] exp_dec(input logic [17:0] a, input logic p);
		logic [2:0] r;
		r = a[13] ? 3'h4 : {1'b0, a[12:11]};
		return {a[8], a[17], r, a[15:14], a[16], a[10], a[7] & p, a[6], a[5:4], a[3:2]};
	endfunction : exp_dec

	task automatic check_all();
		repeat (6) @(posedge clk_in);
		@(negedge clk_in);
		chk_word(stg_w, stg, "staging");
		chk_word(act_w, act, "active");
		dec = {mode, range, gain, neg, clamp, meas_en, cmp_hiz, lead, bypass};
		chk_dec(dec, exp_dec(act, pin_n));
	endtask : check_all

	task automatic send(input logic [17:0] wd, input int n, input int hold);
		int i;
		exp_d = '0;
		for (i = 0; i < n; i++) begin
			exp_d = {exp_d[30:0], sh[17]};
			sh = {sh[16:0], wd[17 - (i % 18)]};
		end
		i_dscp_host_model.frame(wd, n, hold, got);
		if (n > 0) begin
			chk_dout(got, exp_d);
			if (sh[1]) begin
				stg = sh;
			end
			if (sh[0]) begin
				act = stg;
			end
		end else if (hold >= dscp_pkg::CS_MIN_LOW_CYC) begin
			act = stg;
		end
		if (!load_n_in) begin
			act = stg;
		end
	endtask : send

	function automatic logic [17:0] rnd_word(input logic [1:0] code);
		return (18'($random(seed)) & 18'h3FDFC) | {16'h0, code};
	endfunction : rnd_word

	initial begin
		repeat (60000) @(posedge clk_in);
		failures++;
		final_report();
	end

	initial begin
		sh = '0;
		stg = '0;
		act = '0;
		repeat (12) @(posedge clk_in);
		rst_in <= 1'b0;
		check_all();
		// Every transfer code, with odd bit counts now and then
		for (int k = 0; k < 40; k++) begin
			w = rnd_word(2'(k));
			@(posedge clk_in);
			pin_n <= 1'($random(seed));
			send(w, (k % 8 == 7) ? 1 + int'($unsigned($random(seed)) % 25) : 18, 4);
			check_all();
		end
		// Chained update: stage only, strobe after the frame
		send(rnd_word(2'h2), 18, 4);
		check_all();
		@(posedge clk_in);
		load_n_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		load_n_in <= 1'b1;
		act = stg;
		check_all();
		// Strobe held low across the frame end
		@(posedge clk_in);
		load_n_in <= 1'b0;
		send(rnd_word(2'h2), 18, 4);
		@(posedge clk_in);
		load_n_in <= 1'b1;
		check_all();
		// Clockless pulse: too short is ignored, long enough loads
		send(rnd_word(2'h2), 18, 4);
		check_all();
		send(18'h0, 0, 2);
		check_all();
		send(18'h0, 0, 6);
		check_all();
		final_report();
	end
endmodule : test_dscp_serial_control_port
